// >>> logic/drs_defines.svh
// Functional notes
// - each channel path picks input word by field
// - each converter output picks path word by field
// - mask bit forwards sleep pin to block
// - mask bits map to fixed blocks
// - pin sleep and software sleep combine independently
// - 3-bit data delay trim, zero is minimum
// - 3-bit clock delay trim, zero is minimum
// - eight 16-bit expected words check received data
// - words one and two follow sample zero
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define DRS_IDX_ROUTE      7'h22
`define DRS_IDX_MASK       7'h23
`define DRS_IDX_TRIM       7'h24
`define DRS_IDX_WORD0      7'h25
`define DRS_IDX_WORD1      7'h26
`define DRS_IDX_WORD2      7'h27
`define DRS_IDX_TEST_CTRL  7'h38
`define DRS_IDX_TEST_STAT  7'h39
`define DRS_IDX_SOFT_SLEEP 7'h3a

// ****************************************************************
// reset values and fixed pattern words
// ****************************************************************
`define DRS_ROUTE_RST      16'h1b1b
`define DRS_MASK_RST       16'hffff
`define DRS_TRIM_RST       6'h00
`define DRS_WORD0_RST      16'h7a7a
`define DRS_WORD1_RST      16'hb6b6
`define DRS_WORD2_RST      16'heaea
`define DRS_WORD3          16'h4545
`define DRS_WORD4          16'h1a1a
`define DRS_WORD5          16'h1616
`define DRS_WORD6          16'haaaa
`define DRS_WORD7          16'hc6c6
`define DRS_SOFT_RST       16'h0000

// ****************************************************************
// field positions
// ****************************************************************
`define DRS_PATH_SEL_TOP   15
`define DRS_OUT_SEL_TOP    7
`define DRS_TRIM_TOP       15
`define DRS_TRIM_BOT       10
`define DRS_SLEEP_USED     16'hffa0
`define DRS_CTRL_EN_BIT    0
`define DRS_CTRL_CLR_BIT   1
`define DRS_STAT_ALIGN_BIT 8

`endif

// >>> logic/drs_pkg.sv
package drs_pkg;

  typedef logic [15:0] drs_word_t;

  typedef enum logic [1:0] {
    CHK_IDLE,
    CHK_HUNT,
    CHK_RUN
  } drs_chk_state_t;

endpackage

// >>> logic/drs_link_check.sv
`timescale 1ns/1ns
`default_nettype none
module drs_link_check (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    enable_i,
  input  wire logic                    clear_i,
  input  wire logic                    frame_i,
  input  wire drs_pkg::drs_word_t      sample_i,
  input  wire logic [7:0][15:0]        expect_i,
  output var  logic [7:0]              err_flags_o,
  output var  logic                    aligned_o
);

  drs_pkg::drs_chk_state_t state;
  drs_pkg::drs_chk_state_t next_state;
  logic [2:0]              idx;
  logic                    frame_q;

  wire logic       frame_rise = frame_i & ~frame_q;
  wire logic [2:0] cmp_idx    = frame_rise ? 3'h0 : idx;
  wire logic       checking   = enable_i &
                                ((state == drs_pkg::CHK_RUN) | frame_rise);
  wire logic       miss       = checking & (sample_i != expect_i[cmp_idx]);

  always_comb begin
    next_state = state;
    case (state)
      drs_pkg::CHK_IDLE: begin
        // a strobe seen in the enabling cycle already marks sample zero
        if (frame_rise) next_state = drs_pkg::CHK_RUN;
        else if (enable_i) next_state = drs_pkg::CHK_HUNT;
      end
      drs_pkg::CHK_HUNT: if (frame_rise) next_state = drs_pkg::CHK_RUN;
      drs_pkg::CHK_RUN:  next_state = drs_pkg::CHK_RUN;
      default:           next_state = drs_pkg::CHK_IDLE;
    endcase
    if (!enable_i) next_state = drs_pkg::CHK_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= drs_pkg::CHK_IDLE;
      idx     <= 3'h0;
      frame_q <= 1'b0;
    end else begin
      state   <= next_state;
      idx     <= checking ? cmp_idx + 3'h1 : 3'h0;
      frame_q <= frame_i;
    end
  end

  assign aligned_o = (state == drs_pkg::CHK_RUN);

  // a miss in the clearing cycle survives the clear
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_flag
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          err_flags_o[k] <= 1'b0;
        end else begin
          err_flags_o[k] <= (miss & (cmp_idx == k)) |
                            (err_flags_o[k] & ~clear_i);
        end
      end
    end
  endgenerate

  chk_zero_align: assert property (
    @(posedge clk_i) disable iff (rst_i)
    enable_i && frame_rise |=> aligned_o && idx == 3'h1)
    else $error("strobe rise did not mark sample zero");

  chk_index_wrap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    checking && cmp_idx == 3'h7 |=> idx == 3'h0 || !enable_i)
    else $error("sample index did not wrap after eight");

  chk_miss_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    miss && cmp_idx == 3'h2 |=> err_flags_o[2])
    else $error("mismatch on word two not recorded");

endmodule
`default_nettype wire

// >>> logic/drs_regs.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "drs_defines.svh"
module drs_regs (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [8:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output var  logic [31:0]             wb_dat_o,
  output var  logic                    wb_ack_o,
  input  wire logic [3:0][15:0]        in_word_i,
  input  wire logic                    frame_i,
  input  wire drs_pkg::drs_word_t      link_sample_i,
  input  wire logic                    sleep_pin_i,
  output var  logic [3:0][15:0]        path_word_o,
  output var  logic [3:0][15:0]        conv_word_o,
  output var  logic [15:0]             block_sleep_o,
  output var  logic [2:0]              data_delay_o,
  output var  logic [2:0]              clk_delay_o,
  output var  logic                    link_error_o
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  drs_pkg::drs_word_t route;
  drs_pkg::drs_word_t mask;
  logic [5:0]         trim;
  drs_pkg::drs_word_t word0;
  drs_pkg::drs_word_t word1;
  drs_pkg::drs_word_t word2;
  drs_pkg::drs_word_t soft_sleep;
  logic               test_en;

  logic [7:0]         err_flags;
  logic               aligned;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire logic [6:0] idx      = wb_adr_i[8:2];
  wire logic       req      = wb_cyc_i & wb_stb_i;
  // writes land on the edge where ack is seen, as the master expects
  wire logic       wr_go    = req & wb_we_i & wb_ack_o;
  wire logic       rd_go    = req & ~wb_ack_o;

  wire logic hit_route = (idx == `DRS_IDX_ROUTE);
  wire logic hit_mask  = (idx == `DRS_IDX_MASK);
  wire logic hit_trim  = (idx == `DRS_IDX_TRIM);
  wire logic hit_w0    = (idx == `DRS_IDX_WORD0);
  wire logic hit_w1    = (idx == `DRS_IDX_WORD1);
  wire logic hit_w2    = (idx == `DRS_IDX_WORD2);
  wire logic hit_ctrl  = (idx == `DRS_IDX_TEST_CTRL);
  wire logic hit_stat  = (idx == `DRS_IDX_TEST_STAT);
  wire logic hit_soft  = (idx == `DRS_IDX_SOFT_SLEEP);

  // only the two low byte lanes carry register bits
  function automatic drs_pkg::drs_word_t merge(
    input drs_pkg::drs_word_t old_val
  );
    drs_pkg::drs_word_t res;
    res[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : old_val[15:8];
    res[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0]  : old_val[7:0];
    return res;
  endfunction

  wire drs_pkg::drs_word_t trim_word =
    {trim, 10'h000};
  wire drs_pkg::drs_word_t ctrl_word =
    {15'h0000, test_en};
  drs_pkg::drs_word_t trim_new;
  drs_pkg::drs_word_t ctrl_new;

  // always_comb, not assign: merge reads the bus data outside its argument
  always_comb begin
    trim_new = merge(trim_word);
    ctrl_new = merge(ctrl_word);
  end

  wire logic clear_pulse = wr_go & hit_ctrl &
                           ctrl_new[`DRS_CTRL_CLR_BIT];

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route <= `DRS_ROUTE_RST;
    end else if (wr_go && hit_route) begin
      route <= merge(route);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= `DRS_MASK_RST;
    end else if (wr_go && hit_mask) begin
      mask <= merge(mask);
    end
  end

  // reserved low ten bits are not stored and read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim <= `DRS_TRIM_RST;
    end else if (wr_go && hit_trim) begin
      trim <= trim_new[`DRS_TRIM_TOP:`DRS_TRIM_BOT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word0 <= `DRS_WORD0_RST;
    end else if (wr_go && hit_w0) begin
      word0 <= merge(word0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word1 <= `DRS_WORD1_RST;
    end else if (wr_go && hit_w1) begin
      word1 <= merge(word1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word2 <= `DRS_WORD2_RST;
    end else if (wr_go && hit_w2) begin
      word2 <= merge(word2);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_sleep <= `DRS_SOFT_RST;
    end else if (wr_go && hit_soft) begin
      soft_sleep <= merge(soft_sleep);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_en <= 1'b0;
    end else if (wr_go && hit_ctrl) begin
      test_en <= ctrl_new[`DRS_CTRL_EN_BIT];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  drs_pkg::drs_word_t next_rdata;

  always_comb begin
    if (hit_route) begin
      next_rdata = route;
    end else if (hit_mask) begin
      next_rdata = mask;
    end else if (hit_trim) begin
      next_rdata = trim_word;
    end else if (hit_w0) begin
      next_rdata = word0;
    end else if (hit_w1) begin
      next_rdata = word1;
    end else if (hit_w2) begin
      next_rdata = word2;
    end else if (hit_ctrl) begin
      next_rdata = ctrl_word;
    end else if (hit_stat) begin
      next_rdata = {7'h00, aligned, err_flags};
    end else if (hit_soft) begin
      next_rdata = soft_sleep;
    end else begin
      next_rdata = 16'h0000;
    end
  end

  // unmapped indices still answer, with zero data and no write effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= rd_go;
      if (rd_go) begin
        wb_dat_o <= {16'h0000, next_rdata};
      end
    end
  end

  // ****************************************************************
  // channel path and converter output routing
  // ****************************************************************
  // two flop stages: path words, then converter words; latency is fixed
  logic [3:0][15:0] next_path;
  logic [3:0][15:0] next_conv;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_route
      wire logic [1:0] path_sel =
        route[`DRS_PATH_SEL_TOP - 2*ch -: 2];
      wire logic [1:0] out_sel =
        route[`DRS_OUT_SEL_TOP - 2*ch -: 2];
      assign next_path[ch] = in_word_i[path_sel];
      assign next_conv[ch] = path_word_o[out_sel];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      path_word_o <= '0;
      conv_word_o <= '0;
    end else begin
      path_word_o <= next_path;
      conv_word_o <= next_conv;
    end
  end

  // ****************************************************************
  // sleep routing
  // ****************************************************************
  // unused and reserved positions never sleep anything
  wire logic [15:0] pin_sleep =
    {16{sleep_pin_i}} & mask & `DRS_SLEEP_USED;
  wire logic [15:0] next_sleep =
    (pin_sleep | soft_sleep) & `DRS_SLEEP_USED;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_sleep_o <= 16'h0000;
    end else begin
      block_sleep_o <= next_sleep;
    end
  end

  // ****************************************************************
  // receiver delay trims
  // ****************************************************************
  // the trims only reach the analog receivers; no timing is modeled here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_delay_o <= 3'h0;
      clk_delay_o  <= 3'h0;
    end else begin
      data_delay_o <= trim[5:3];
      clk_delay_o  <= trim[2:0];
    end
  end

  // ****************************************************************
  // input interface test
  // ****************************************************************
  wire logic [7:0][15:0] expect_words = {
    `DRS_WORD7, `DRS_WORD6, `DRS_WORD5, `DRS_WORD4,
    `DRS_WORD3, word2, word1, word0
  };

  drs_link_check u_check (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .enable_i    (test_en),
    .clear_i     (clear_pulse),
    .frame_i     (frame_i),
    .sample_i    (link_sample_i),
    .expect_i    (expect_words),
    .err_flags_o (err_flags),
    .aligned_o   (aligned)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_error_o <= 1'b0;
    end else begin
      link_error_o <= |err_flags;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_route_reset: assert property (
    @(posedge clk_i)
    $past(rst_i) |-> route == `DRS_ROUTE_RST && mask == `DRS_MASK_RST)
    else $error("route or mask reset value wrong");

  chk_path_to_conv: assert property (
    @(posedge clk_i) disable iff (rst_i)
    route[7:6] == 2'h1 ##1 route[7:6] == 2'h1
    |-> conv_word_o[0] == $past(path_word_o[1]))
    else $error("converter a not fed by selected path");

  chk_pin_sleep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sleep_pin_i && mask[15] |=> block_sleep_o[15])
    else $error("sleep pin not forwarded to converter a");

  chk_sleep_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    block_sleep_o[6] == 1'b0 && block_sleep_o[4:0] == 5'h00)
    else $error("unused sleep position asserted");

  chk_soft_sleep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    soft_sleep[11] |=> block_sleep_o[11])
    else $error("software sleep overridden by pin routing");

  chk_trim_follow: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_go && hit_trim && wb_sel_i[1]
    |=> ##1 clk_delay_o == $past(wb_dat_i[12:10], 2))
    else $error("clock delay trim did not follow write");

  chk_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// >>> dv/drs_source.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// data source on the parallel input bus
// ****************************************************************
module drs_source (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic [3:0]       bad_i,
  input  wire logic [7:0][15:0] words_i,
  output var  logic [3:0][15:0] in_word_o,
  output var  logic             frame_o,
  output var  logic [15:0]      sample_o
);
  logic [11:0] cnt;
  logic [2:0]  idx;
  logic        run_q;
  wire  [2:0]  pick = run_q ? idx : 3'h0;

  // words change every cycle so a stale mux pick cannot pass
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      in_word_o[n] = {2'(n), 2'h0, cnt};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt      <= 12'h000;
      idx      <= 3'h0;
      run_q    <= 1'b0;
      frame_o  <= 1'b0;
      sample_o <= 16'h0000;
    end else begin
      cnt     <= cnt + 12'h001;
      run_q   <= run_i;
      frame_o <= run_i & ~run_q;
      if (run_i) begin
        // one bit flipped on the chosen index; 8 means no fault
        sample_o <= words_i[pick] ^ {7'h00, {1'b0, pick} == bad_i, 8'h00};
        idx      <= pick + 3'h1;
      end else begin
        // released line: no stale value left standing
        sample_o <= ~sample_o;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/drs_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "drs_defines.svh"
module drs_regs_test;
  logic             clk, rst, cyc, stb, we, ack, frame, pin, link_err, run;
  logic [8:0]       adr;
  logic [3:0]       sel, bad;
  logic [31:0]      wdat, rdat;
  logic [3:0][15:0] in_w, path_w, conv_w;
  logic [15:0]      lsample, bsleep, rd;
  logic [2:0]       ddly, cdly;
  logic [7:0][15:0] words;
  int               err_count, n_checks;
  logic [6:0]       ri [7] = '{7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h10};
  logic [15:0]      rv [7] = '{16'h1b1b, 16'hffff, 16'h0000, 16'h7a7a,
                               16'hb6b6, 16'heaea, 16'h0000};

  drs_regs dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .in_word_i(in_w), .frame_i(frame),
    .link_sample_i(lsample), .sleep_pin_i(pin), .path_word_o(path_w),
    .conv_word_o(conv_w), .block_sleep_o(bsleep), .data_delay_o(ddly),
    .clk_delay_o(cdly), .link_error_o(link_err));

  drs_source src_u (.clk_i(clk), .rst_i(rst), .run_i(run), .bad_i(bad),
    .words_i(words), .in_word_o(in_w), .frame_o(frame), .sample_o(lsample));

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [6:0] idx,
                      input logic [15:0] d, output logic [15:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= 4'hf;
    wdat <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic route(input logic [15:0] r);
    logic [3:0][15:0] w;
    logic [3:0][15:0] p;
    xfer(1'b1, `DRS_IDX_ROUTE, r, rd);
    @(negedge clk);
    w = in_w;
    @(negedge clk);
    p = path_w;
    for (int i = 0; i < 4; i++) check("path", p[i], w[r[15-2*i -: 2]]);
    @(negedge clk);
    for (int j = 0; j < 4; j++) check("conv", conv_w[j], p[r[7-2*j -: 2]]);
    @(posedge clk);
  endtask

  task automatic sleep(input logic [15:0] m, input logic [15:0] s,
                       input logic p);
    xfer(1'b1, `DRS_IDX_MASK, m, rd);
    xfer(1'b1, `DRS_IDX_SOFT_SLEEP, s, rd);
    pin <= p;
    repeat (2) @(negedge clk);
    check("sleep", bsleep, ((p ? m : 16'h0000) | s) & 16'hffa0);
    @(posedge clk);
  endtask

  task automatic link(input logic [3:0] b, input logic [7:0] f);
    xfer(1'b1, `DRS_IDX_TEST_CTRL, 16'h0002, rd);
    xfer(1'b1, `DRS_IDX_TEST_CTRL, 16'h0001, rd);
    bad <= b;
    run <= 1'b1;
    repeat (20) @(posedge clk);
    xfer(1'b0, `DRS_IDX_TEST_STAT, 16'h0000, rd);
    check("status", rd, {7'h00, 1'b1, f});
    check("link_err", {15'h0000, link_err}, {15'h0000, |f});
    xfer(1'b1, `DRS_IDX_TEST_CTRL, 16'h0000, rd);
    run <= 1'b0;
    @(posedge clk);
  endtask

  task automatic conclude();
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // whole sequence takes well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    {rst, cyc, stb, we, pin, run} = 6'b100000;
    adr   = 9'h000;
    sel   = 4'h0;
    wdat  = 32'h0;
    bad   = 4'h8;
    words = {16'hc6c6, 16'haaaa, 16'h1616, 16'h1a1a,
             16'h4545, 16'heaea, 16'hb6b6, 16'h7a7a};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ri[i], 16'h0000, rd);
      check("reset value", rd, rv[i]);
    end
    xfer(1'b1, 7'h10, 16'hffff, rd);
    xfer(1'b0, 7'h10, 16'h0000, rd);
    check("unmapped", rd, 16'h0000);
    route(16'h1b1b);
    route(16'he41b);
    route(16'h1be4);
    route(16'h4e72);
    xfer(1'b1, `DRS_IDX_TRIM, 16'ha7ff, rd);
    xfer(1'b0, `DRS_IDX_TRIM, 16'h0000, rd);
    check("trim", rd, 16'ha400);
    check("data delay", {13'h0, ddly}, 16'h0005);
    check("clk delay", {13'h0, cdly}, 16'h0001);
    sleep(16'hffff, 16'h0000, 1'b1);
    sleep(16'h1234, 16'h0000, 1'b1);
    sleep(16'h1234, 16'h0000, 1'b0);
    sleep(16'h1234, 16'h0080, 1'b0);
    sleep(16'h1234, 16'h0080, 1'b1);
    sleep(16'h0000, 16'h0880, 1'b1);
    xfer(1'b1, `DRS_IDX_WORD0, 16'h1234, rd);
    xfer(1'b1, `DRS_IDX_WORD1, 16'h5a5a, rd);
    xfer(1'b0, `DRS_IDX_WORD1, 16'h0000, rd);
    check("word one", rd, 16'h5a5a);
    words[0] <= 16'h1234;
    words[1] <= 16'h5a5a;
    link(4'h8, 8'h00);
    link(4'h0, 8'h01);
    link(4'h2, 8'h04);
    link(4'h3, 8'h08);
    link(4'h7, 8'h80);
    conclude();
  end
endmodule
`default_nettype wire
